// [ssr_pkg.sv]
// Constants and types for the shadowed SRAM save/restore host controller
// Functional notes
// - Host holds chip select and write enable low together at least 100ns.
// - Host keeps a strobe high until address valid; address held through write.
// - Host times write data to the first rising strobe edge.
// - Host starts a save with a low pulse of at least 100ns.
// - Host issues no access during 10ms after a save request.
// - Host starts a restore with a low pulse of at least 450ns.
package ssr_pkg;
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int T_WR_PULSE_NS   = 100;
  localparam int T_ADDR_SETUP_NS = 300;
  localparam int T_ACC_ADDR_NS   = 300;
  localparam int T_ACC_CS_NS     = 200;
  localparam int T_SAVE_PULSE_NS = 100;
  localparam int T_SAVE_MS       = 10;
  localparam int T_REST_PULSE_NS = 450;
  localparam int T_REST_READ_NS  = 750;
  // Least times round up to whole cycles
  localparam int WR_CYC      = (T_WR_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CYC     = (T_ACC_ADDR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACC_CS_CYC  = (T_ACC_CS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SETUP_CYC   = 1;
  localparam int HOLD_CYC    = 1;
  localparam int SAVE_P_CYC  = (T_SAVE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REST_P_CYC  = (T_REST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REST_R_CYC  = (T_REST_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Save wait in ns over period in ns, so the product stays within 32 bits
  localparam int SAVE_CYC    = (T_SAVE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int CNT_W       = 20;
  localparam int ADDR_W_DEF  = 8;
  localparam int DATA_W_DEF  = 4;
  localparam logic [1:0] CMD_READ    = 2'h0;
  localparam logic [1:0] CMD_WRITE   = 2'h1;
  localparam logic [1:0] CMD_SAVE    = 2'h2;
  localparam logic [1:0] CMD_RESTORE = 2'h3;
  typedef enum logic [2:0] {
    SSR_IDLE, SSR_SETUP, SSR_STROBE, SSR_HOLD, SSR_SAVE_P, SSR_SAVE_W, SSR_REST_P, SSR_REST_W
  } ssr_state_t;
endpackage

// [ssr_timer.sv]
// Down counter that times pulses and waits for the host sequencer
`timescale 1ns/1ps
module ssr_timer
  import ssr_pkg::*;
#(
  parameter int W = CNT_W
) (
  // Clock and reset
  input  wire logic         CLK_SYS,
  input  wire logic         ARST_N,
  // Load and status
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] count;

  // Load wins; otherwise count down to zero
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      count <= '0;
    end else if (load) begin
      count <= value;
    end else if (count != '0) begin
      count <= count - 1'b1;
    end
  end

  // Done reads the count only, since the sequencer loads on done
  assign done = (count == '0);
endmodule // ssr_timer

// [ssr_host.sv]
// Host sequencer driving the shadowed SRAM pins for read, write, save, restore
`timescale 1ns/1ps
module ssr_host
  import ssr_pkg::*;
#(
  parameter int ADDR_W   = ADDR_W_DEF,
  parameter int DATA_W   = DATA_W_DEF,
  parameter int SAVE_WAIT = SAVE_CYC
) (
  // Clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              ARST_N,
  // User command port
  input  wire logic              CMD_VALID,
  input  wire logic [1:0]        CMD_OP,
  input  wire logic [ADDR_W-1:0] CMD_ADDR,
  input  wire logic [DATA_W-1:0] CMD_WDATA,
  output logic                   CMD_READY,
  output logic                   RSP_VALID,
  output logic [DATA_W-1:0]      RSP_RDATA,
  output logic                   BUSY_SAVE,
  // Memory pins
  output logic [ADDR_W-1:0]      MEM_ADDR,
  output logic                   MEM_CS_N,
  output logic                   MEM_WE_N,
  output logic                   MEM_SAVE_N,
  output logic                   MEM_REST_N,
  output logic [DATA_W-1:0]      MEM_DQ_O,
  output logic                   MEM_DQ_OE,
  input  wire logic [DATA_W-1:0] MEM_DQ_I
);
  ssr_state_t        state;
  logic [1:0]        op;
  logic              tmr_load;
  logic [CNT_W-1:0]  tmr_value;
  logic              tmr_done;

  // Converts a cycle count to the timer width
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // True in the cycles that keep the strobe pair low
  function automatic logic in_window(input ssr_state_t s, input logic done);
    in_window = ((s == SSR_SETUP) && done) || ((s == SSR_STROBE) && !done);
  endfunction

  // True when the idle sequencer takes a command of the given kind
  function automatic logic takes(input ssr_state_t s, input logic valid,
                                 input logic [1:0] cur, input logic [1:0] want);
    takes = (s == SSR_IDLE) && valid && (cur == want);
  endfunction

  ssr_timer #(.W(CNT_W)) u_timer (
    .CLK_SYS (CLK_SYS),
    .ARST_N  (ARST_N),
    .load    (tmr_load),
    .value   (tmr_value),
    .done    (tmr_done)
  );

  assign CMD_READY = (state == SSR_IDLE);
  assign BUSY_SAVE = (state == SSR_SAVE_P) || (state == SSR_SAVE_W);

  // Timer loads on each state entry except the return to idle
  always_comb begin
    tmr_load  = 1'b0;
    tmr_value = '0;
    case (state)
      SSR_IDLE: begin
        if (CMD_VALID) begin
          tmr_load = 1'b1;
          case (CMD_OP)
            CMD_SAVE:    tmr_value = cyc(SAVE_P_CYC);
            CMD_RESTORE: tmr_value = cyc(REST_P_CYC);
            default:     tmr_value = cyc(SETUP_CYC);
          endcase
        end
      end
      SSR_SETUP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          // Read waits worst access, the longer of the address and select figures
          if (op == CMD_READ) begin
            tmr_value = cyc((ACC_CYC > ACC_CS_CYC) ? ACC_CYC : ACC_CS_CYC);
          end else begin
            tmr_value = cyc(WR_CYC);
          end
        end
      end
      SSR_STROBE: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = cyc(HOLD_CYC);
        end
      end
      SSR_SAVE_P: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = cyc(SAVE_WAIT - SAVE_P_CYC);
        end
      end
      SSR_REST_P: begin
        if (tmr_done) begin
          tmr_load  = 1'b1;
          tmr_value = cyc(REST_R_CYC);
        end
      end
      default: begin
        tmr_load  = 1'b0;
        tmr_value = '0;
      end
    endcase
  end

  // Sequencer; one operation at a time so save and restore never overlap
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= SSR_IDLE;
      op    <= CMD_READ;
    end else begin
      case (state)
        SSR_IDLE: begin
          if (CMD_VALID) begin
            op <= CMD_OP;
            case (CMD_OP)
              CMD_SAVE:    state <= SSR_SAVE_P;
              CMD_RESTORE: state <= SSR_REST_P;
              default:     state <= SSR_SETUP;
            endcase
          end
        end
        SSR_SETUP:  if (tmr_done) state <= SSR_STROBE;
        SSR_STROBE: if (tmr_done) state <= SSR_HOLD;
        SSR_HOLD:   if (tmr_done) state <= SSR_IDLE;
        SSR_SAVE_P: if (tmr_done) state <= SSR_SAVE_W;
        SSR_SAVE_W: if (tmr_done) state <= SSR_IDLE;
        SSR_REST_P: if (tmr_done) state <= SSR_REST_W;
        SSR_REST_W: if (tmr_done) state <= SSR_IDLE;
        default:    state <= SSR_IDLE;
      endcase
    end
  end

  // Address latched as a command is taken, held through hold
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_ADDR <= '0;
    end else if (state == SSR_IDLE && CMD_VALID) begin
      MEM_ADDR <= CMD_ADDR;
    end
  end

  // Write data latched with the address
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_DQ_O <= '0;
    end else if (state == SSR_IDLE && CMD_VALID) begin
      MEM_DQ_O <= CMD_WDATA;
    end
  end

  // Chip select low for the strobe window of reads and writes
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_CS_N <= 1'b1;
    end else begin
      MEM_CS_N <= !in_window(state, tmr_done);
    end
  end

  // Write enable shares the window, so both rise at one edge
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_WE_N <= 1'b1;
    end else begin
      MEM_WE_N <= !((op == CMD_WRITE) && in_window(state, tmr_done));
    end
  end

  // Data driven from take until one cycle after the strobes rise
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_DQ_OE <= 1'b0;
    end else begin
      MEM_DQ_OE <= takes(state, CMD_VALID, CMD_OP, CMD_WRITE) ||
                   ((op == CMD_WRITE) && ((state == SSR_SETUP) || (state == SSR_STROBE)));
    end
  end

  // Save pulse from take until its timer runs out
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_SAVE_N <= 1'b1;
    end else begin
      MEM_SAVE_N <= !(takes(state, CMD_VALID, CMD_OP, CMD_SAVE) || ((state == SSR_SAVE_P) && !tmr_done));
    end
  end

  // Restore pulse from take until its timer runs out
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      MEM_REST_N <= 1'b1;
    end else begin
      MEM_REST_N <= !(takes(state, CMD_VALID, CMD_OP, CMD_RESTORE) || ((state == SSR_REST_P) && !tmr_done));
    end
  end

  // Response strobe for one cycle as the strobes rise
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RSP_VALID <= 1'b0;
    end else begin
      RSP_VALID <= (state == SSR_STROBE) && tmr_done;
    end
  end

  // Read data sampled while chip select is still low
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      RSP_RDATA <= '0;
    end else if ((state == SSR_STROBE) && tmr_done && (op == CMD_READ)) begin
      RSP_RDATA <= MEM_DQ_I;
    end
  end
endmodule // ssr_host

// [ssr_props.sv]
// Checker for the host pin timing of the shadowed SRAM controller
`timescale 1ns/1ps
module ssr_props
  import ssr_pkg::*;
#(
  parameter int ADDR_W    = ADDR_W_DEF,
  parameter int DATA_W    = DATA_W_DEF,
  parameter int SAVE_WAIT = SAVE_CYC
) (
  // Clock and reset
  input wire logic              CLK_SYS,
  input wire logic              ARST_N,
  // Status
  input wire logic              CMD_READY,
  input wire logic              RSP_VALID,
  input wire logic              BUSY_SAVE,
  // Memory pins
  input wire logic [ADDR_W-1:0] MEM_ADDR,
  input wire logic              MEM_CS_N,
  input wire logic              MEM_WE_N,
  input wire logic              MEM_SAVE_N,
  input wire logic              MEM_REST_N,
  input wire logic [DATA_W-1:0] MEM_DQ_O,
  input wire logic              MEM_DQ_OE
);
  logic [7:0]       rest_cnt;
  logic [CNT_W-1:0] save_cnt;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  // Restore low time and save wait length
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rest_cnt <= 8'h00;
      save_cnt <= '0;
    end else begin
      rest_cnt <= MEM_REST_N ? 8'h00 : rest_cnt + 8'h01;
      save_cnt <= BUSY_SAVE ? save_cnt + 1'b1 : '0;
    end
  end
  a_wr_low: assert property ($fell(MEM_WE_N) |-> (!MEM_WE_N && !MEM_CS_N) [*4]) else $error("short write");
  a_addr_held: assert property (!MEM_CS_N |-> $stable(MEM_ADDR)) else $error("address moved");
  a_data_held: assert property (!MEM_WE_N |-> MEM_DQ_OE && $stable(MEM_DQ_O)) else $error("data moved");
  a_wr_resp: assert property ($rose(MEM_WE_N) |-> ##[0:2] RSP_VALID) else $error("no write answer");
  a_save_low: assert property ($fell(MEM_SAVE_N) |-> !MEM_SAVE_N [*4]) else $error("short save");
  a_rest_low: assert property ($rose(MEM_REST_N) |-> rest_cnt >= REST_P_CYC) else $error("short restore");
  a_save_quiet: assert property (BUSY_SAVE |-> MEM_CS_N && MEM_REST_N && !CMD_READY) else $error("access in save");
  a_save_wait: assert property ($fell(BUSY_SAVE) |-> save_cnt >= SAVE_WAIT) else $error("save wait short");
  c_write: cover property ($fell(MEM_WE_N));
  c_save: cover property ($fell(BUSY_SAVE));
  c_rest: cover property ($rose(MEM_REST_N));
  c_read: cover property (RSP_VALID && MEM_WE_N && !MEM_DQ_OE);
endmodule // ssr_props
bind ssr_host ssr_props #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .SAVE_WAIT(SAVE_WAIT)) ssr_props_i (.CLK_SYS, .ARST_N,
  .CMD_READY, .RSP_VALID, .BUSY_SAVE, .MEM_ADDR, .MEM_CS_N, .MEM_WE_N, .MEM_SAVE_N, .MEM_REST_N, .MEM_DQ_O, .MEM_DQ_OE);

// [ssr_mem_model.sv]
// Behavioural shadowed SRAM answering the host pins
`timescale 1ns/1ps
module ssr_mem_model #(
  parameter int ADDR_W  = 8,
  parameter int DATA_W  = 4,
  parameter int SAVE_NS = 1000
) (
  // Strobes and address
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              cs_n,
  input wire logic              we_n,
  input wire logic              save_n,
  input wire logic              rest_n,
  // Data pins
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic              dq_oe,
  output logic [DATA_W-1:0]     dq_i
);
  logic [DATA_W-1:0] ram [2**ADDR_W];
  logic [DATA_W-1:0] nv [2**ADDR_W];
  logic [DATA_W-1:0] last = '0;
  logic              saving = 1'b0;
  logic              rd_ok = 1'b0;
  realtime           t_addr = 0.0;
  realtime           t_cs = 0.0;
  realtime           t_rest = -1000.0;
  wire               wr_act = !cs_n && !we_n && !saving && rest_n;
  wire               drive = !cs_n && we_n && rd_ok && !saving && rest_n;
  // Word lands as the overlap ends; a cut write leaves it unknown
  always @(negedge wr_act) ram[addr] = (saving || !dq_oe) ? 'x : dq_o;
  // Time stamps of address change, select fall and restore end
  always @(addr) t_addr = $realtime;
  always @(negedge cs_n) t_cs = $realtime;
  always @(posedge rest_n) t_rest = $realtime;
  // Data shows only after the latest of the access times
  always #5 rd_ok = !cs_n && ($realtime - t_addr >= 300.0) && ($realtime - t_cs >= 200.0) &&
                    ($realtime - t_rest >= 750.0);
  // Save copies all words and cannot be stopped
  always @(negedge save_n) if (!saving && rest_n) begin
    saving = 1'b1;
    nv = ram;
    #SAVE_NS saving = 1'b0;
  end
  // Restore replaces RAM unless a save runs
  always @(negedge rest_n) if (!saving) ram = nv;
  // Floating lines show the inverse of the last value
  always @* if (drive) last = ram[addr];
  always @* dq_i = dq_oe ? dq_o : (drive ? ram[addr] : ~last);
endmodule // ssr_mem_model

// [ssr_host_tb.sv]
// Testbench for the shadowed SRAM host controller
`timescale 1ns/1ps
module ssr_host_tb
  import ssr_pkg::*;
;
  logic       CLK_SYS = 1'b0;
  logic       ARST_N = 1'b0;
  logic       cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [7:0] cmd_addr = 8'h00;
  logic [3:0] cmd_wdata = 4'h0;
  logic       cmd_ready, rsp_valid, busy_save, cs_n, we_n, save_n, rest_n, dq_oe;
  logic [3:0] rsp_rdata, dq_o, dq_i;
  logic [7:0] addr;
  int         err_total = 0;
  int         cmp_count = 0;
  ssr_host #(.SAVE_WAIT(50)) ssr_host_i (.CLK_SYS, .ARST_N, .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_ADDR(cmd_addr), .CMD_WDATA(cmd_wdata), .CMD_READY(cmd_ready), .RSP_VALID(rsp_valid),
    .RSP_RDATA(rsp_rdata), .BUSY_SAVE(busy_save), .MEM_ADDR(addr), .MEM_CS_N(cs_n), .MEM_WE_N(we_n),
    .MEM_SAVE_N(save_n), .MEM_REST_N(rest_n), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe), .MEM_DQ_I(dq_i));
  ssr_mem_model #(.SAVE_NS(1000)) ssr_mem_model_i (.addr, .cs_n, .we_n, .save_n, .rest_n, .dq_o, .dq_oe, .dq_i);
  // Clock
  initial forever #12.5 CLK_SYS = ~CLK_SYS;
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [3:0] d);
    @(negedge CLK_SYS);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    while (cmd_ready !== 1'b1) @(negedge CLK_SYS);
    @(negedge CLK_SYS);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_rsp;
    for (int i = 0; i < 40 && rsp_valid !== 1'b1; i++) @(negedge CLK_SYS);
    chk({3'h0, rsp_valid}, 4'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] exp);
    cmd(CMD_READ, a, 4'h0);
    wait_rsp();
    chk(rsp_rdata, exp);
  endtask
  task automatic t_write_read;
    cmd(CMD_WRITE, 8'h00, 4'hA);
    wait_rsp();
    cmd(CMD_WRITE, 8'hFF, 4'h5);
    wait_rsp();
    cmd(CMD_WRITE, 8'h3C, 4'hC);
    wait_rsp();
    rd(8'hFF, 4'h5);
    rd(8'h00, 4'hA);
    $display("write_read done");
  endtask
  task automatic t_save_restore;
    cmd(CMD_SAVE, 8'h00, 4'h0);
    chk({3'h0, busy_save}, 4'h1);
    rd(8'h3C, 4'hC);
    cmd(CMD_WRITE, 8'h00, 4'h3);
    wait_rsp();
    rd(8'h00, 4'h3);
    cmd(CMD_RESTORE, 8'h00, 4'h0);
    rd(8'h00, 4'hA);
    rd(8'hFF, 4'h5);
    $display("save_restore done");
  endtask
  // Reset in the middle of a read, then normal service again
  task automatic t_reset;
    cmd(CMD_READ, 8'h3C, 4'h0);
    repeat (3) @(negedge CLK_SYS);
    chk({3'h0, cs_n}, 4'h0);
    ARST_N = 1'b0;
    @(negedge CLK_SYS);
    chk({cs_n, we_n, save_n, rest_n}, 4'hF);
    chk({busy_save, dq_oe, rsp_valid, cmd_ready}, 4'h1);
    ARST_N = 1'b1;
    rd(8'hFF, 4'h5);
    $display("reset done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #50000;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    t_write_read();
    t_reset();
    t_save_restore();
    complete_run();
  end
endmodule // ssr_host_tb
